// >>> rtl/bsfce_flash_ctrl.sv
// module: AHB-Lite controlled command engine that drives a boot-sector flash over its pins
// What the datasheet requires
// R1: device holds 131,072 bytes, one byte per address, eight data lines.
// R2: array is ten sectors: one 8K, two 4K, seven 16K.
// R3: device comes with boot sectors at top or at bottom.
// R4: separate active-low chip select, write strobe, output enable avoid contention.
// R5: commands go out as ordinary bus write cycles to the device.
// R6: device latches address and data on every write cycle.
// R7: device times and verifies programming on its own after the sequence.
// R8: program takes four writes, unlock-bypass program only two.
// R9: device preprograms, then erases and verifies with self-timed pulses.
// R10: erase covers whole chip or any chosen sectors.
// R11: progress shows on polling and toggle bits; host polls for completion.
// R12: device returns to read mode after program or erase ends.
// R13: erasing one sector leaves other sectors untouched.
// R14: device ignores writes while supply is in transition.
// R15: protected sectors refuse program and erase.
// R16: temporary unprotect lets locked sectors be changed.
// R17: sector erase may be suspended indefinitely; other sectors usable meanwhile. Engine rejects commands while busy, so no suspend mid-erase.
// R18: hardware reset aborts any operation, back to read mode. Engine issues OP_HW_RESET only when idle, never mid-operation.
// R19: device sleeps by itself when address stays stable long enough.
// R20: host can put device into low-power standby.
// R21: device drives data only with chip select and output enable low, write high.
// R22: while busy, polling bit reads inverted and toggle bit flips every read.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
module bsfce_flash_ctrl
  import bsfce_pkg::*;
#(
  parameter logic [31:0] POLL_LIMIT = 32'h00ffffff
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [16:0] flash_addr_o,
  output logic [7:0] byte_data_lines_o,
  output logic byte_data_lines_oe_o,
  input wire logic [7:0] byte_data_lines_i,
  output bsfce_pkg::bsfce_ctl_t flash_ctl_o
);

  typedef enum logic [5:0] {
    FC_IDLE = 6'b000001,
    FC_ISSUE = 6'b000010,
    FC_WAITW = 6'b000100,
    FC_POLL = 6'b001000,
    FC_WAITR = 6'b010000,
    FC_WAITRST = 6'b100000
  } bsfce_fc_st_t;

  typedef struct packed {
    bsfce_fc_st_t st;
    bsfce_op_t op;
    logic [16:0] addr;
    logic [7:0] data;
    logic [2:0] idx;
    logic start;
    bsfce_kind_t kind;
    bsfce_cyc_t cyc;
    logic have_prev;
    logic prev_tgl;
    logic [31:0] poll_cnt;
    logic busy;
    logic done;
    logic err;
    logic susp;
    logic byp;
    logic [7:0] rbyte;
    logic a_sel;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } bsfce_fc_t;

  bsfce_fc_t s;
  bsfce_fc_t next_s;
  logic pc_done;
  logic [7:0] pc_rdata;

  bsfce_pin_cycle u_pin (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(s.start),
    .kind_i(s.kind),
    .cyc_i(s.cyc),
    .byte_data_lines_i(byte_data_lines_i),
    .done_o(pc_done),
    .rdata_o(pc_rdata),
    .addr_o(flash_addr_o),
    .byte_data_lines_o(byte_data_lines_o),
    .byte_data_lines_oe_o(byte_data_lines_oe_o),
    .ctl_o(flash_ctl_o)
  );

  function automatic logic [31:0] reg_read(logic [7:0] a, bsfce_fc_t c);
    logic [31:0] r;
    r = 32'h00000000;
    if (a == REG_ADDR) begin
      r[16:0] = c.addr;
    end else if (a == REG_DATA) begin
      r[7:0] = c.data;
    end else if (a == REG_STATUS) begin
      r[ST_BUSY] = c.busy;
      r[ST_DONE] = c.done;
      r[ST_ERR] = c.err;
      r[ST_SUSP] = c.susp;
      r[ST_BYP] = c.byp;
      r[ST_RBYTE +: 8] = c.rbyte;
    end else if (a == REG_CMD) begin
      r[3:0] = c.op;
    end
    return r;
  endfunction

  logic wr_phase;
  logic wr_cmd;
  logic wr_addr;
  logic wr_data;
  logic poll_stop;
  logic last_step;

  always_comb begin
    wr_phase = s.a_sel && s.a_write;
    // addresses, data and commands are frozen while a command runs
    wr_cmd = wr_phase && (s.a_addr == REG_CMD) && !s.busy;
    wr_addr = wr_phase && (s.a_addr == REG_ADDR) && !s.busy;
    wr_data = wr_phase && (s.a_addr == REG_DATA) && !s.busy;
    // toggle bit stopped between two reads means the routine has ended
    poll_stop = s.have_prev && (pc_rdata[TOGGLE_STATUS_BIT] == s.prev_tgl); // [R11] [R22]
    last_step = (s.idx == bsfce_seq_len(s.op) - 3'h1);
  end

  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    // slave side: zero wait states, always OKAY
    next_s.hready = 1'b1;
    next_s.hresp = 1'b0;
    if (hready_i) begin
      next_s.a_sel = hsel_i && htrans_i[1];
      next_s.a_write = hwrite_i;
      next_s.a_addr = haddr_i[7:0];
      if (hsel_i && htrans_i[1] && !hwrite_i) begin
        next_s.hrdata = reg_read(haddr_i[7:0], s);
      end
    end
    if (wr_addr) begin
      next_s.addr = hwdata_i[16:0]; // [R1]
    end
    if (wr_data) begin
      next_s.data = hwdata_i[7:0];
    end
    case (s.st)
      FC_IDLE: begin
        if (wr_cmd) begin
          next_s.op = bsfce_op_t'(hwdata_i[3:0]);
          next_s.idx = 3'h0;
          next_s.done = 1'b0;
          next_s.err = 1'b0;
          next_s.busy = 1'b1;
          next_s.cyc = '{addr: s.addr, data: s.data};
          if (hwdata_i[3:0] == OP_READ) begin
            next_s.kind = BUS_READ; // [R21]
            next_s.start = 1'b1;
            next_s.st = FC_WAITR;
          end else if (hwdata_i[3:0] == OP_HW_RESET) begin
            next_s.kind = BUS_RESET; // [R18]
            next_s.start = 1'b1;
            next_s.st = FC_WAITRST;
          end else if (hwdata_i[3:0] > OP_HW_RESET) begin
            // unknown codes finish at once without touching the pins
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end else begin
            next_s.st = FC_ISSUE;
          end
        end
      end
      FC_ISSUE: begin
        next_s.kind = BUS_WRITE; // [R5] [R6]
        next_s.cyc = bsfce_seq_step(s.op, s.idx, s.addr, s.data); // [R8] [R10]
        next_s.start = 1'b1;
        next_s.st = FC_WAITW;
      end
      FC_WAITW: begin
        if (pc_done) begin
          if (!last_step) begin
            next_s.idx = s.idx + 3'h1; // [R8]
            next_s.st = FC_ISSUE;
          end else if (bsfce_needs_poll(s.op)) begin
            // device runs its own algorithm now; only status reads go out
            next_s.kind = BUS_READ; // [R7] [R9]
            next_s.cyc = '{addr: s.addr, data: 8'h00};
            next_s.start = 1'b1;
            next_s.have_prev = 1'b0;
            next_s.poll_cnt = 32'h00000000;
            next_s.st = FC_POLL;
          end else begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.st = FC_IDLE;
            if (s.op == OP_BYP_ENTER) begin
              next_s.byp = 1'b1; // [R8]
            end else if (s.op == OP_BYP_EXIT) begin
              next_s.byp = 1'b0;
            end else if (s.op == OP_RESUME) begin
              next_s.susp = 1'b0; // [R17]
            end
          end
        end
      end
      FC_POLL: begin
        if (pc_done) begin
          next_s.rbyte = pc_rdata;
          if (poll_stop) begin
            // back in read mode: a programmed byte must read back its polling bit (bit 7) as written
            next_s.busy = 1'b0; // [R12]
            next_s.done = 1'b1;
            next_s.st = FC_IDLE;
            if ((s.op == OP_PROGRAM || s.op == OP_BYP_PROGRAM) &&
                (pc_rdata[POLLING_STATUS_BIT] != s.data[POLLING_STATUS_BIT])) begin
              next_s.err = 1'b1; // [R11] [R15]
            end
            if (s.op == OP_SUSPEND) begin
              next_s.susp = 1'b1; // [R17]
            end
          end else if (s.poll_cnt == POLL_LIMIT) begin
            // a stuck operation whose toggle bit never stops ends here instead of hanging
            next_s.err = 1'b1;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.st = FC_IDLE;
          end else begin
            next_s.prev_tgl = pc_rdata[TOGGLE_STATUS_BIT]; // [R22]
            next_s.have_prev = 1'b1;
            next_s.poll_cnt = s.poll_cnt + 32'h00000001;
            next_s.start = 1'b1; // [R11]
          end
        end
      end
      FC_WAITR: begin
        if (pc_done) begin
          next_s.rbyte = pc_rdata; // [R21]
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.st = FC_IDLE;
        end
      end
      FC_WAITRST: begin
        if (pc_done) begin
          next_s.busy = 1'b0; // [R18]
          next_s.done = 1'b1;
          next_s.byp = 1'b0;
          next_s.susp = 1'b0;
          next_s.st = FC_IDLE;
        end
      end
      default: next_s.st = FC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s <= '{st: FC_IDLE, op: OP_READ, addr: 17'h00000, data: 8'h00, idx: 3'h0, start: 1'b0,
             kind: BUS_READ, cyc: '{addr: 17'h00000, data: 8'h00}, have_prev: 1'b0, prev_tgl: 1'b0,
             poll_cnt: 32'h00000000, busy: 1'b0, done: 1'b0, err: 1'b0, susp: 1'b0, byp: 1'b0,
             rbyte: 8'h00, a_sel: 1'b0, a_write: 1'b0, a_addr: 8'h00, hrdata: 32'h00000000,
             hready: 1'b1, hresp: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign hrdata_o = s.hrdata;
  assign hreadyout_o = s.hready;
  assign hresp_o = s.hresp;

endmodule

// >>> rtl/bsfce_pkg.sv
// package: constants, types and command-sequence tables for the flash command engine
package bsfce_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // clock rate and pin timing (least times, rounded up to whole cycles)
  localparam int CLK_MHZ = 20;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int WP_RAW = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_RAW = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_RAW = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int RH_RAW = (T_RH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] WP_CYC = 8'((WP_RAW < 1) ? 1 : WP_RAW);
  localparam logic [7:0] ACC_CYC = 8'((ACC_RAW < 1) ? 1 : ACC_RAW);
  localparam logic [7:0] RP_CYC = 8'((RP_RAW < 1) ? 1 : RP_RAW);
  localparam logic [7:0] RH_CYC = 8'((RH_RAW < 1) ? 1 : RH_RAW);

  // register offsets (low address byte)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_SUSP = 3;
  localparam int ST_BYP = 4;
  localparam int ST_RBYTE = 8;

  // polling and toggle status bit positions on the data lines
  localparam int POLLING_STATUS_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;

  // command bytes and unlock addresses written to the device
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_BYP_ENTER = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [16:0] ADDR_UNLOCK1 = 17'h00555;
  localparam logic [16:0] ADDR_UNLOCK2 = 17'h002aa;

  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_WRITE = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_BYP_PROGRAM = 4'h3,
    OP_BYP_ENTER = 4'h4,
    OP_BYP_EXIT = 4'h5,
    OP_CHIP_ERASE = 4'h6,
    OP_SECTOR_ERASE = 4'h7,
    OP_SUSPEND = 4'h8,
    OP_RESUME = 4'h9,
    OP_RESET_CMD = 4'ha,
    OP_HW_RESET = 4'hb
  } bsfce_op_t;

  typedef enum logic [1:0] {
    BUS_READ = 2'h0,
    BUS_WRITE = 2'h1,
    BUS_RESET = 2'h2
  } bsfce_kind_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic reset_n;
  } bsfce_ctl_t;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } bsfce_cyc_t;

  function automatic logic [2:0] bsfce_seq_len(bsfce_op_t op);
    case (op)
      OP_PROGRAM: return 3'h4;
      OP_BYP_PROGRAM: return 3'h2;
      OP_BYP_ENTER: return 3'h3;
      OP_BYP_EXIT: return 3'h2;
      OP_CHIP_ERASE: return 3'h6;
      OP_SECTOR_ERASE: return 3'h6;
      default: return 3'h1;
    endcase
  endfunction

  function automatic logic bsfce_needs_poll(bsfce_op_t op);
    return (op == OP_PROGRAM) || (op == OP_BYP_PROGRAM) || (op == OP_CHIP_ERASE) ||
           (op == OP_SECTOR_ERASE) || (op == OP_SUSPEND);
  endfunction

  function automatic bsfce_cyc_t bsfce_seq_step(bsfce_op_t op, logic [2:0] idx, logic [16:0] a, logic [7:0] d);
    bsfce_cyc_t r;
    r = '{addr: a, data: d};
    if (idx == 3'h0 || idx == 3'h3) begin
      r = '{addr: ADDR_UNLOCK1, data: CMD_UNLOCK1};
    end else if (idx == 3'h1 || idx == 3'h4) begin
      r = '{addr: ADDR_UNLOCK2, data: CMD_UNLOCK2};
    end else if (idx == 3'h2) begin
      r = '{addr: ADDR_UNLOCK1, data: (op == OP_BYP_ENTER) ? CMD_BYP_ENTER :
            (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP};
    end
    case (op)
      OP_PROGRAM: if (idx == 3'h3) r = '{addr: a, data: d};
      OP_BYP_PROGRAM: r = '{addr: a, data: (idx == 3'h0) ? CMD_PROGRAM : d};
      OP_BYP_EXIT: r = '{addr: a, data: (idx == 3'h0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2};
      OP_CHIP_ERASE: if (idx == 3'h5) r = '{addr: ADDR_UNLOCK1, data: CMD_CHIP_ERASE};
      OP_SECTOR_ERASE: if (idx == 3'h5) r = '{addr: a, data: CMD_SECTOR_ERASE};
      OP_SUSPEND: r = '{addr: a, data: CMD_SUSPEND};
      OP_RESUME: r = '{addr: a, data: CMD_RESUME};
      OP_RESET_CMD: r = '{addr: a, data: CMD_RESET};
      OP_WRITE: r = '{addr: a, data: d};
      default: ;
    endcase
    return r;
  endfunction

endpackage

// >>> rtl/bsfce_pin_cycle.sv
// module: one timed read, write or reset-pulse cycle on the flash pins
module bsfce_pin_cycle
  import bsfce_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire bsfce_pkg::bsfce_kind_t kind_i,
  input wire bsfce_pkg::bsfce_cyc_t cyc_i,
  input wire logic [7:0] byte_data_lines_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic [16:0] addr_o,
  output logic [7:0] byte_data_lines_o,
  output logic byte_data_lines_oe_o,
  output bsfce_pkg::bsfce_ctl_t ctl_o
);

  typedef enum logic [3:0] {
    PC_IDLE = 4'b0001,
    PC_SETUP = 4'b0010,
    PC_STROBE = 4'b0100,
    PC_HOLD = 4'b1000
  } bsfce_pc_st_t;

  typedef struct packed {
    bsfce_pc_st_t st;
    bsfce_kind_t kind;
    logic [7:0] cnt;
    logic [16:0] addr;
    logic [7:0] dout;
    logic oe;
    bsfce_ctl_t ctl;
    logic done;
    logic [7:0] rdata;
  } bsfce_pc_t;

  bsfce_pc_t s;
  bsfce_pc_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      PC_IDLE: begin
        if (start_i) begin
          next_s.kind = kind_i;
          next_s.addr = cyc_i.addr;
          next_s.dout = cyc_i.data;
          if (kind_i == BUS_WRITE) begin
            // outputs stay off whenever data is driven [R4]
            next_s.ctl.ce_n = 1'b0;
            next_s.oe = 1'b1;
            next_s.st = PC_SETUP;
          end else if (kind_i == BUS_READ) begin
            next_s.ctl.ce_n = 1'b0; // [R21]
            next_s.ctl.oe_n = 1'b0; // [R21]
            next_s.cnt = ACC_CYC - 8'h01;
            next_s.st = PC_STROBE;
          end else begin
            next_s.ctl.reset_n = 1'b0; // [R18]
            next_s.cnt = RP_CYC - 8'h01;
            next_s.st = PC_STROBE;
          end
        end
      end
      PC_SETUP: begin
        next_s.ctl.we_n = 1'b0; // [R5]
        next_s.cnt = WP_CYC - 8'h01;
        next_s.st = PC_STROBE;
      end
      PC_STROBE: begin
        if (s.cnt != 8'h00) begin
          next_s.cnt = s.cnt - 8'h01;
        end else begin
          next_s.st = PC_HOLD;
          if (s.kind == BUS_WRITE) begin
            next_s.ctl.we_n = 1'b1;
          end else if (s.kind == BUS_READ) begin
            next_s.rdata = byte_data_lines_i;
            next_s.ctl.ce_n = 1'b1;
            next_s.ctl.oe_n = 1'b1;
          end else begin
            next_s.ctl.reset_n = 1'b1;
            next_s.cnt = RH_CYC - 8'h01;
          end
        end
      end
      PC_HOLD: begin
        if (s.cnt != 8'h00) begin
          next_s.cnt = s.cnt - 8'h01;
        end else begin
          // chip deselected between cycles keeps the device in standby
          next_s.ctl.ce_n = 1'b1; // [R20]
          next_s.oe = 1'b0;
          next_s.done = 1'b1;
          next_s.st = PC_IDLE;
        end
      end
      default: next_s.st = PC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s <= '{st: PC_IDLE, kind: BUS_READ, cnt: 8'h00, addr: 17'h00000, dout: 8'h00, oe: 1'b0,
             ctl: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1}, done: 1'b0, rdata: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  assign done_o = s.done;
  assign rdata_o = s.rdata;
  assign addr_o = s.addr;
  assign byte_data_lines_o = s.dout;
  assign byte_data_lines_oe_o = s.oe;
  assign ctl_o = s.ctl;

endmodule

// >>> verification/bsfce_flash_ctrl_sva.sv
// checker: pin and bus timing assertions for the command engine
module bsfce_flash_ctrl_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [16:0] flash_addr_o,
  input wire logic [7:0] byte_data_lines_o,
  input wire logic byte_data_lines_oe_o,
  input wire bsfce_pkg::bsfce_ctl_t flash_ctl_o
);
  timeunit 1ns / 1ps;
  import bsfce_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_bus_always_ready: assert property (hreadyout_o) else $error("hready dropped");
  a_bus_resp_okay: assert property (!hresp_o) else $error("error response seen");
  a_no_contention: assert property (byte_data_lines_oe_o |-> flash_ctl_o.oe_n)
    else $error("bus contention");
  a_write_needs_select: assert property (!flash_ctl_o.we_n |-> !flash_ctl_o.ce_n && flash_ctl_o.oe_n)
    else $error("strobe without select");
  a_write_pulse_width: assert property ($fell(flash_ctl_o.we_n) |=> flash_ctl_o.we_n)
    else $error("write strobe not one cycle");
  a_write_data_held: assert property ($fell(flash_ctl_o.we_n) |-> byte_data_lines_oe_o ##1
    (byte_data_lines_oe_o && $stable(flash_addr_o) && $stable(byte_data_lines_o)))
    else $error("write hold broken");
  a_read_window: assert property ($fell(flash_ctl_o.oe_n) |-> (!flash_ctl_o.ce_n && flash_ctl_o.we_n &&
    !byte_data_lines_oe_o) ##1 !flash_ctl_o.oe_n ##1 flash_ctl_o.oe_n)
    else $error("read window wrong");
  a_reset_pulse_len: assert property ($fell(flash_ctl_o.reset_n) |-> !flash_ctl_o.reset_n [*8] ##1
    !flash_ctl_o.reset_n ##1 !flash_ctl_o.reset_n ##1 flash_ctl_o.reset_n)
    else $error("reset pulse length");
  a_reset_quiet: assert property (!flash_ctl_o.reset_n |-> flash_ctl_o.ce_n && !byte_data_lines_oe_o)
    else $error("pins busy in reset");
endmodule

bind bsfce_flash_ctrl bsfce_flash_ctrl_sva bsfce_flash_ctrl_sva_i (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .flash_addr_o(flash_addr_o),
  .byte_data_lines_o(byte_data_lines_o),
  .byte_data_lines_oe_o(byte_data_lines_oe_o),
  .flash_ctl_o(flash_ctl_o)
);

// >>> verification/bsfce_flash_model.sv
// model: byte-wide boot-sector flash behind the engine's pins
module bsfce_flash_model #(
  parameter bit TOP_BOOT = 1'b1,
  parameter int PROG_READS = 3,
  parameter int ERASE_READS = 6
) (
  input wire logic [16:0] addr_i,
  input wire logic [7:0] ctrl_data_i,
  input wire logic ctrl_oe_i,
  input wire bsfce_pkg::bsfce_ctl_t ctl_i,
  input wire logic [9:0] prot_i,
  input wire logic unprot_i,
  input wire logic vdd_low_i,
  output logic [7:0] data_o
);
  timeunit 1ns / 1ps;
  import bsfce_pkg::*;
  logic [7:0] mem [int]; // absent bytes read erased
  logic [7:0] q = 8'h00, last = 8'h00, pend = 8'hff;
  logic tog = 1'b0, byp = 1'b0;
  int st = 0, busy = 0;
  wire drv = !ctl_i.ce_n && !ctl_i.oe_n && ctl_i.we_n && ctl_i.reset_n;
  function automatic int sec(input int a);
    int m;
    m = TOP_BOOT ? a : 'h1ffff - a; // bottom variant mirrors the map
    return (m < 'h1c000) ? m / 'h4000 : (m < 'h1d000) ? 7 : (m < 'h1e000) ? 8 : 9;
  endfunction
  function automatic logic lock(input int a);
    return prot_i[sec(a)] && !unprot_i;
  endfunction
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // preprogramming is skipped: it cannot change what a finished erase leaves behind
  task automatic erase(input logic all, input int s);
    for (int i = 0; i < 131072; i++) begin
      if ((all || sec(i) == s) && !lock(i)) mem.delete(i);
    end
    pend = 8'hff;
    busy = ERASE_READS;
  endtask
  always @(posedge ctl_i.we_n) begin
    if (!ctl_i.ce_n && ctl_i.reset_n && busy == 0 && !vdd_low_i) begin // dropped while busy or supply low
      if (ctrl_data_i == CMD_RESET) st = 0;
      else case (st)
        0: st = (byp && ctrl_data_i == CMD_PROGRAM) ? 3 : (byp && ctrl_data_i == CMD_BYP_EXIT1) ? 7 :
          (addr_i == ADDR_UNLOCK1 && ctrl_data_i == CMD_UNLOCK1) ? 1 : 0;
        1: st = (addr_i == ADDR_UNLOCK2 && ctrl_data_i == CMD_UNLOCK2) ? 2 : 0;
        2: begin
          st = (ctrl_data_i == CMD_PROGRAM) ? 3 : (ctrl_data_i == CMD_ERASE_SETUP) ? 4 : 0;
          if (ctrl_data_i == CMD_BYP_ENTER) byp = 1'b1;
        end
        3: begin
          st = 0;
          pend = ctrl_data_i;
          busy = PROG_READS;
          if (!lock(addr_i)) mem[addr_i] = rd(addr_i) & ctrl_data_i;
        end
        4: st = (ctrl_data_i == CMD_UNLOCK1) ? 5 : 0;
        5: st = (ctrl_data_i == CMD_UNLOCK2) ? 6 : 0;
        6: begin
          st = 0;
          if (ctrl_data_i == CMD_CHIP_ERASE) erase(1'b1, 0);
          else if (ctrl_data_i == CMD_SECTOR_ERASE) erase(1'b0, sec(addr_i));
        end
        default: begin
          st = 0;
          if (ctrl_data_i == CMD_BYP_EXIT2) byp = 1'b0;
        end
      endcase
    end
  end
  always @(posedge drv) #1 q = (busy > 0) ? {~pend[7], tog, pend[5:0]} : rd(addr_i);
  always @(negedge drv) begin
    last = q;
    if (busy > 0) begin
      tog = ~tog;
      busy = busy - 1;
    end
  end
  always @(negedge ctrl_oe_i) last = ctrl_data_i;
  always @(negedge ctl_i.reset_n) begin
    st = 0;
    byp = 1'b0;
    busy = 0;
  end
  // released lines show the inverse of the last value so a stale sample cannot pass
  assign data_o = ctrl_oe_i ? ctrl_data_i : drv ? q : ~last;
endmodule

// >>> verification/bsfce_flash_ctrl_tb.sv
// testbench: register traffic over the bus through the engine into the flash model
module bsfce_flash_ctrl_tb;
  timeunit 1ns / 1ps;
  import bsfce_pkg::*;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
    string n;
  } bsfce_note_t;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, rd_dp = 1'b0, unprot = 1'b0, low = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, r;
  logic [1:0] htrans_i = 2'h0;
  logic hreadyout_o, hresp_o, byte_data_lines_oe_o;
  logic [16:0] flash_addr_o;
  logic [7:0] byte_data_lines_o, byte_data_lines_i;
  bsfce_ctl_t flash_ctl_o;
  logic [9:0] prot = 10'h200;
  int fail_count = 0, num_checks = 0, seed = 5;
  bsfce_note_t notes[$];
  logic [16:0] ta[4];
  logic [7:0] td[4];
  always #25 ref_clk_i = ~ref_clk_i;
  // short poll limit keeps a stuck poll cheap in simulation
  bsfce_flash_ctrl #(.POLL_LIMIT(32'd20)) bsfce_flash_ctrl_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .flash_addr_o(flash_addr_o), .byte_data_lines_o(byte_data_lines_o),
    .byte_data_lines_oe_o(byte_data_lines_oe_o), .byte_data_lines_i(byte_data_lines_i),
    .flash_ctl_o(flash_ctl_o));
  bsfce_flash_model bsfce_flash_model_i (.addr_i(flash_addr_o), .ctrl_data_i(byte_data_lines_o),
    .ctrl_oe_i(byte_data_lines_oe_o), .ctl_i(flash_ctl_o), .prot_i(prot), .unprot_i(unprot), .vdd_low_i(low),
    .data_o(byte_data_lines_i));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    if (hreadyout_o !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    wait_ready();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_ready();
    r = hrdata_o;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
    notes.push_back('{e, m, n});
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic run(input logic [3:0] op);
    int n = 0;
    ahb(1'b1, REG_CMD, {28'h0, op});
    rd(REG_STATUS, 0, 0, "");
    do begin
      rd(REG_STATUS, 0, 0, "");
      n++;
    end while (r[ST_BUSY] !== 1'b0 && n < 400);
    if (r[ST_BUSY] !== 1'b0) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic prog(input logic [3:0] op, input logic [16:0] a, input logic [7:0] d, input logic e,
    input logic [7:0] b);
    ahb(1'b1, REG_ADDR, {15'h0, a});
    ahb(1'b1, REG_DATA, {24'h0, d});
    run(op);
    rd(REG_STATUS, {16'h0, b, 5'h0, e, 2'h2}, 32'h0000ff07, "program status");
  endtask
  task automatic peek(input logic [16:0] a, input logic [7:0] b);
    ahb(1'b1, REG_ADDR, {15'h0, a});
    run(OP_READ);
    rd(REG_STATUS, {16'h0, b, 8'h02}, 32'h0000ff03, "read byte");
  endtask
  // every read data phase settles the oldest note
  always @(posedge ref_clk_i) begin
    bsfce_note_t nt;
    if (rd_dp && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.m != 32'h0) begin
        num_checks++;
        if ((hrdata_o & nt.m) !== (nt.e & nt.m)) begin
          fail_count++;
          $display("wrong value %s expected %h seen %h", nt.n, nt.e & nt.m, hrdata_o & nt.m);
        end
      end
    end
    rd_dp <= hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o;
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(REG_STATUS, 0, 32'hffffffff, "status after reset");
    rd(REG_CMD, 0, 32'hffffffff, "command after reset");
    ahb(1'b1, 8'h10, 32'h12345678);
    rd(8'h10, 0, 32'hffffffff, "unmapped offset");
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      ta[k] = 17'(k * 'h4000 + ($random(seed) & 'h3fff));
      td[k] = 8'($random(seed));
      prog(OP_PROGRAM, ta[k], td[k], 1'b0, td[k]);
    end
    for (int k = 0; k < 4; k++) begin
      peek(ta[k], td[k]);
    end
    $display("test program done");
    run(OP_BYP_ENTER);
    rd(REG_STATUS, 32'h12, 32'h13, "bypass on");
    prog(OP_BYP_PROGRAM, 17'h1c010, 8'h3c, 1'b0, 8'h3c);
    run(OP_BYP_EXIT);
    rd(REG_STATUS, 32'h02, 32'h13, "bypass off");
    peek(17'h1c010, 8'h3c);
    $display("test bypass done");
    ahb(1'b1, REG_ADDR, {15'h0, ta[0]});
    run(OP_SECTOR_ERASE);
    peek(ta[0], 8'hff);
    peek(ta[1], td[1]);
    prog(OP_PROGRAM, 17'h1e123, 8'h5a, 1'b1, 8'hff);
    unprot <= 1'b1;
    prog(OP_PROGRAM, 17'h1e123, 8'h5a, 1'b0, 8'h5a);
    unprot <= 1'b0;
    run(OP_CHIP_ERASE);
    peek(ta[2], 8'hff);
    peek(17'h1e123, 8'h5a);
    low <= 1'b1;
    prog(OP_PROGRAM, ta[2], 8'h5a, 1'b1, 8'hff);
    low <= 1'b0;
    $display("test erase done");
    for (int i = 0; i < 6; i++) begin
      run((i == 5) ? OP_WRITE : 4'(8 + i));
      rd(REG_STATUS, {28'h0, i == 0, 3'h2}, (i < 2) ? 32'hb : 32'h3, "mode status");
    end
    peek(17'h1e123, 8'h5a);
    $display("test modes done");
    report_and_stop();
  end
endmodule
